// [design/vic_pkg.sv]
// package: register map, field positions, vectors and reset values of the interrupt control unit
package vic_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h0b;
  localparam logic [7:0] ADDR_CTRL1 = 8'h1e;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;

  // ----------------------------------------------------------------
  // field positions, control register 0
  // ----------------------------------------------------------------
  localparam int B_GLOBAL_EN = 0;
  localparam int B_CMP_EN = 1;
  localparam int B_GEXT_EN = 2;
  localparam int B_SEXT_EN = 3;
  localparam int B_CMP_PEND = 4;
  localparam int B_GEXT_PEND = 5;
  localparam int B_SEXT_PEND = 6;

  // ----------------------------------------------------------------
  // field positions, control register 1
  // ----------------------------------------------------------------
  localparam int B_PWM_EN = 0;
  localparam int B_TMRA_EN = 1;
  localparam int B_TMRB_EN = 2;
  localparam int B_PWM_PEND = 4;
  localparam int B_TMRA_PEND = 5;
  localparam int B_TMRB_PEND = 6;

  // ----------------------------------------------------------------
  // sources and vectors
  // ----------------------------------------------------------------
  localparam int NSRC = 6;
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam logic [7:0] VEC_CMP = 8'h04;
  localparam logic [7:0] VEC_GEXT = 8'h08;
  localparam logic [7:0] VEC_SEXT = 8'h0c;
  localparam logic [7:0] VEC_PWM = 8'h10;
  localparam logic [7:0] VEC_TMRA = 8'h14;
  localparam logic [7:0] VEC_TMRB = 8'h18;

  typedef enum {VIC_IDLE, VIC_ACK} vic_state_t;

endpackage

// [design/vic_prio.sv]
// fixed-priority picker: lowest index wins, returns source index or none
module vic_prio
(
  // requests, index 0 has highest priority
  input wire logic [5:0] req,
  // winner
  output logic [2:0] sel,
  output logic any
);

  always_comb
  begin
    sel = vic_pkg::SRC_NONE;
    any = 1'b0;
    for (int i = vic_pkg::NSRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        sel = 3'(i);
        any = 1'b1;
      end
    end
  end

endmodule // vic_prio

// [design/vic_ctrl.sv]
// interrupt control unit: two control registers, request latching, priority and acknowledge
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module vic_ctrl
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // request sources, pins are asynchronous
  input wire logic comparator_out,
  input wire logic grouped_ext_line_a,
  input wire logic grouped_ext_line_b,
  input wire logic grouped_ext_line_c,
  input wire logic single_ext_line,
  input wire logic [3:0] ext_edge_rising,
  input wire logic pwm_period_tick,
  input wire logic timer_a_overflow,
  input wire logic timer_b_overflow,
  // core sequencer
  input wire logic phase_two_pulse,
  input wire logic interrupt_exit_instruction,
  input wire logic plain_subroutine_exit,
  input wire logic stack_full,
  output logic irq_call,
  output logic [7:0] irq_vector
);

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  logic global_irq_enable;
  logic comparator_irq_enable;
  logic grouped_ext_irq_enable;
  logic single_ext_irq_enable;
  logic pwm_period_irq_enable;
  logic timer_a_irq_enable;
  logic timer_b_irq_enable;
  logic [5:0] pend;
  logic [5:0] set_ev;
  logic [5:0] sw_clr;
  logic [5:0] ack_clr;
  logic [5:0] en_vec;
  logic [2:0] win;
  logic win_any;
  logic wr0;
  logic wr1;
  logic take;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  // stage one feeds stage two only; edges are taken between stage two and three
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [4:0] pin_in;
  logic [4:0] rise;
  logic [4:0] fall;
  logic [2:0] live;

  assign pin_in = {single_ext_line, grouped_ext_line_c, grouped_ext_line_b, grouped_ext_line_a, comparator_out};

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      live <= 3'h0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      live <= {live[1:0], 1'b1};
    end
  end

  // edges count only once stage three holds a real sample, so a pin idling high gives no false edge
  assign rise = sync2 & ~sync3 & {5{live[2]}};
  assign fall = ~sync2 & sync3 & {5{live[2]}};

  function automatic logic pick_edge(input logic r, input logic f, input logic up);
    pick_edge = up ? r : f;
  endfunction

  // external lines use a software-chosen edge, index into ext_edge_rising
  always_comb
  begin
    set_ev = 6'h00;
    set_ev[0] = fall[0];
    set_ev[1] = pick_edge(rise[1], fall[1], ext_edge_rising[0]) | pick_edge(rise[2], fall[2], ext_edge_rising[1])
      | pick_edge(rise[3], fall[3], ext_edge_rising[2]);
    set_ev[2] = pick_edge(rise[4], fall[4], ext_edge_rising[3]);
    set_ev[3] = pwm_period_tick;
    set_ev[4] = timer_a_overflow;
    set_ev[5] = timer_b_overflow;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr0 = wr && (addr == vic_pkg::ADDR_CTRL0);
  assign wr1 = wr && (addr == vic_pkg::ADDR_CTRL1);

  always_comb
  begin
    sw_clr = 6'h00;
    if (wr0)
    begin
      sw_clr[0] = ~wdata[vic_pkg::B_CMP_PEND];
      sw_clr[1] = ~wdata[vic_pkg::B_GEXT_PEND];
      sw_clr[2] = ~wdata[vic_pkg::B_SEXT_PEND];
    end
    if (wr1)
    begin
      sw_clr[3] = ~wdata[vic_pkg::B_PWM_PEND];
      sw_clr[4] = ~wdata[vic_pkg::B_TMRA_PEND];
      sw_clr[5] = ~wdata[vic_pkg::B_TMRB_PEND];
    end
  end

  // software may also set a flag by writing one, as with any register bit
  logic [5:0] sw_set;
  always_comb
  begin
    sw_set = 6'h00;
    if (wr0)
    begin
      sw_set[0] = wdata[vic_pkg::B_CMP_PEND];
      sw_set[1] = wdata[vic_pkg::B_GEXT_PEND];
      sw_set[2] = wdata[vic_pkg::B_SEXT_PEND];
    end
    if (wr1)
    begin
      sw_set[3] = wdata[vic_pkg::B_PWM_PEND];
      sw_set[4] = wdata[vic_pkg::B_TMRA_PEND];
      sw_set[5] = wdata[vic_pkg::B_TMRB_PEND];
    end
  end

  // global enable: exit sets, else acknowledge clears, else software write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      global_irq_enable <= vic_pkg::CTRL0_RST[vic_pkg::B_GLOBAL_EN];
    else if (interrupt_exit_instruction)
      global_irq_enable <= 1'b1;
    else if (take)
      global_irq_enable <= 1'b0;
    else if (wr0)
      global_irq_enable <= wdata[vic_pkg::B_GLOBAL_EN];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      comparator_irq_enable <= vic_pkg::CTRL0_RST[vic_pkg::B_CMP_EN];
      grouped_ext_irq_enable <= vic_pkg::CTRL0_RST[vic_pkg::B_GEXT_EN];
      single_ext_irq_enable <= vic_pkg::CTRL0_RST[vic_pkg::B_SEXT_EN];
    end
    else if (wr0)
    begin
      comparator_irq_enable <= wdata[vic_pkg::B_CMP_EN];
      grouped_ext_irq_enable <= wdata[vic_pkg::B_GEXT_EN];
      single_ext_irq_enable <= wdata[vic_pkg::B_SEXT_EN];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pwm_period_irq_enable <= vic_pkg::CTRL1_RST[vic_pkg::B_PWM_EN];
      timer_a_irq_enable <= vic_pkg::CTRL1_RST[vic_pkg::B_TMRA_EN];
      timer_b_irq_enable <= vic_pkg::CTRL1_RST[vic_pkg::B_TMRB_EN];
    end
    else if (wr1)
    begin
      pwm_period_irq_enable <= wdata[vic_pkg::B_PWM_EN];
      timer_a_irq_enable <= wdata[vic_pkg::B_TMRA_EN];
      timer_b_irq_enable <= wdata[vic_pkg::B_TMRB_EN];
    end
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  // a hardware set in the same cycle as any clear wins, so no event is lost
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pend <= 6'h00;
    else
      pend <= set_ev | sw_set | (pend & ~sw_clr & ~ack_clr);
  end

  // ----------------------------------------------------------------
  // priority and acknowledge
  // ----------------------------------------------------------------
  assign en_vec = {timer_b_irq_enable, timer_a_irq_enable, pwm_period_irq_enable,
    single_ext_irq_enable, grouped_ext_irq_enable, comparator_irq_enable};

  vic_prio u_prio
  (
    .req(pend & en_vec),
    .sel(win),
    .any(win_any)
  );

  // sampling only on the pulse means anything latched since the last pulse is seen now
  assign take = phase_two_pulse && global_irq_enable && win_any && !stack_full;

  always_comb
  begin
    ack_clr = 6'h00;
    if (take)
      ack_clr[win] = 1'b1;
  end

  function automatic logic [7:0] vec_of(input logic [2:0] s);
    case (s)
      3'h0: vec_of = vic_pkg::VEC_CMP;
      3'h1: vec_of = vic_pkg::VEC_GEXT;
      3'h2: vec_of = vic_pkg::VEC_SEXT;
      3'h3: vec_of = vic_pkg::VEC_PWM;
      3'h4: vec_of = vic_pkg::VEC_TMRA;
      3'h5: vec_of = vic_pkg::VEC_TMRB;
      default: vec_of = 8'h00;
    endcase
  endfunction

  // call pulse and vector: the core pushes the pc itself on the pulse
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_call <= 1'b0;
      irq_vector <= 8'h00;
    end
    else
    begin
      irq_call <= take;
      if (take)
        irq_vector <= vec_of(win);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata <= 8'h00;
    else if (rd && addr == vic_pkg::ADDR_CTRL0)
      rdata <= {1'b0, pend[2:0], single_ext_irq_enable, grouped_ext_irq_enable,
        comparator_irq_enable, global_irq_enable};
    else if (rd && addr == vic_pkg::ADDR_CTRL1)
      rdata <= {1'b0, pend[5:3], 1'b0, timer_b_irq_enable, timer_a_irq_enable, pwm_period_irq_enable};
    else
      rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_mask;
    @(posedge clk) disable iff (!nrst) !global_irq_enable |=> !irq_call;
  endproperty
  a_mask: assert property (p_mask) else $error("call while masked");

  property p_full;
    @(posedge clk) disable iff (!nrst) stack_full |=> !irq_call;
  endproperty
  a_full: assert property (p_full) else $error("call with stack full");

  property p_sample;
    @(posedge clk) disable iff (!nrst) irq_call |-> $past(phase_two_pulse);
  endproperty
  a_sample: assert property (p_sample) else $error("call off the pulse");

  property p_gie_clr;
    @(posedge clk) disable iff (!nrst) irq_call && !$past(interrupt_exit_instruction) |-> !global_irq_enable;
  endproperty
  a_gie_clr: assert property (p_gie_clr) else $error("global enable kept on acknowledge");

  property p_exit;
    @(posedge clk) disable iff (!nrst) interrupt_exit_instruction |=> global_irq_enable;
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not set global enable");

  property p_ret;
    @(posedge clk) disable iff (!nrst)
      plain_subroutine_exit && !interrupt_exit_instruction && !take && !wr0 |=> $stable(global_irq_enable);
  endproperty
  a_ret: assert property (p_ret) else $error("plain exit changed global enable");

  property p_cmp_first;
    @(posedge clk) disable iff (!nrst) take && pend[0] && comparator_irq_enable |=> irq_vector == vic_pkg::VEC_CMP;
  endproperty
  a_cmp_first: assert property (p_cmp_first) else $error("comparator not first");

  property p_tmrb_vec;
    @(posedge clk) disable iff (!nrst) take && (pend & en_vec) == 6'h20 |=> irq_vector == vic_pkg::VEC_TMRB;
  endproperty
  a_tmrb_vec: assert property (p_tmrb_vec) else $error("wrong timer b vector");

  property p_hold;
    @(posedge clk) disable iff (!nrst) pend[4] && !take && !wr1 |=> pend[4];
  endproperty
  a_hold: assert property (p_hold) else $error("timer a flag dropped");

  property p_tmr_set;
    @(posedge clk) disable iff (!nrst) timer_a_overflow |=> pend[4];
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("overflow not latched");

  c_call: cover property (@(posedge clk) disable iff (!nrst) irq_call);
  c_two: cover property (@(posedge clk) disable iff (!nrst) take && $countones(pend & en_vec) > 1);
  c_full: cover property (@(posedge clk) disable iff (!nrst) phase_two_pulse && stack_full && win_any);

endmodule // vic_ctrl

// [verification/vic_core_model.sv]
// partner model: core sequencer phase pulses and a return stack of limited depth
module vic_core_model
#(
  parameter int STACK_DEPTH = 2
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // sequencer
  input wire logic irq_call,
  input wire logic interrupt_exit_instruction,
  input wire logic plain_subroutine_exit,
  output logic phase_two_pulse,
  output logic stack_full
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;
  logic [3:0] depth;
  // ----------------------------------------------------------------
  // one sampling pulse per four-clock instruction cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase <= 2'h0;
      phase_two_pulse <= 1'b0;
    end
    else
    begin
      phase <= phase + 2'h1;
      phase_two_pulse <= (phase == 2'h3);
    end
  end
  // ----------------------------------------------------------------
  // stack: a call pushes, either return pops; full blocks the caller
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      depth <= 4'h0;
    else if (irq_call)
      depth <= depth + 4'h1;
    else if ((interrupt_exit_instruction || plain_subroutine_exit) && depth != 4'h0)
      depth <= depth - 4'h1;
  end
  assign stack_full = (int'(depth) >= STACK_DEPTH);
endmodule // vic_core_model

// [verification/tb.sv]
// testbench: register tasks, interrupt scenarios and the closing report
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, wr, rd, cmp_out, gext_a, gext_b, gext_c, sext, pwm, tma, tmb, p2, rexit, pexit, sfull, call;
  logic [7:0] addr, wdata, rdata, vec;
  logic [3:0] edge_sel;
  logic [7:0] vecs [0:5];
  logic [5:0] left;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // design and partner
  // ----------------------------------------------------------------
  vic_ctrl vic_ctrl_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .comparator_out(cmp_out), .grouped_ext_line_a(gext_a), .grouped_ext_line_b(gext_b),
    .grouped_ext_line_c(gext_c), .single_ext_line(sext), .ext_edge_rising(edge_sel), .pwm_period_tick(pwm),
    .timer_a_overflow(tma), .timer_b_overflow(tmb), .phase_two_pulse(p2), .interrupt_exit_instruction(rexit),
    .plain_subroutine_exit(pexit), .stack_full(sfull), .irq_call(call), .irq_vector(vec));
  vic_core_model vic_core_model_inst (.clk(clk), .nrst(nrst), .irq_call(call), .interrupt_exit_instruction(rexit),
    .plain_subroutine_exit(pexit), .phase_two_pulse(p2), .stack_full(sfull));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check8(rdata, exp);
  endtask
  // the answer may only come on a sampling pulse, so allow several instruction cycles
  task automatic wait_call(input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 40 && !seen; n++)
    begin
      @(posedge clk);
      #1;
      seen = (call === 1'b1);
    end
    check8({7'h0, seen}, 8'h01);
    check8(vec, exp);
  endtask
  task automatic no_call(input int n);
    logic hit;
    hit = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (call === 1'b1)
        hit = 1'b1;
    end
    check8({7'h0, hit}, 8'h00);
  endtask
  task automatic exit_pulse(input logic from_irq);
    @(posedge clk);
    if (from_irq)
      rexit <= 1'b1;
    else
      pexit <= 1'b1;
    @(posedge clk);
    rexit <= 1'b0;
    pexit <= 1'b0;
  endtask
  task automatic end_test(input string name);
    $display("test %s finished, miscompares %0d", name, miscompares);
  endtask
  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      complete_run;
    end
  end
  initial
  begin
    {nrst, wr, rd, gext_a, gext_b, gext_c, sext, pwm, tma, tmb, rexit, pexit} = 12'h000;
    cmp_out = 1'b1;
    edge_sel = 4'h1;
    addr = 8'h00;
    wdata = 8'h00;
    vecs = '{vic_pkg::VEC_CMP, vic_pkg::VEC_GEXT, vic_pkg::VEC_SEXT, vic_pkg::VEC_PWM, vic_pkg::VEC_TMRA,
      vic_pkg::VEC_TMRB};
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    chk_reg(vic_pkg::ADDR_CTRL0, vic_pkg::CTRL0_RST);
    chk_reg(vic_pkg::ADDR_CTRL1, vic_pkg::CTRL1_RST);
    wr_reg(vic_pkg::ADDR_CTRL0, 8'hfe);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h7e);
    wr_reg(vic_pkg::ADDR_CTRL1, 8'hff);
    chk_reg(vic_pkg::ADDR_CTRL1, 8'h77);
    wr_reg(8'h0c, 8'hff);
    chk_reg(8'h0c, 8'h00);
    end_test("registers");
    // all six pending at once, released one by one through interrupt exit
    left = 6'h3f;
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h7f);
    for (int i = 0; i < 6; i++)
    begin
      wait_call(vecs[i]);
      left[i] = 1'b0;
      chk_reg(vic_pkg::ADDR_CTRL0, {1'b0, left[2:0], 4'he});
      chk_reg(vic_pkg::ADDR_CTRL1, {1'b0, left[5:3], 4'h7});
      exit_pulse(1'b1);
    end
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h0f);
    end_test("priority");
    // masked sources latch and wait
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h0e);
    @(posedge clk);
    {pwm, tma, tmb} <= 3'h7;
    @(posedge clk);
    {pwm, tma, tmb} <= 3'h0;
    no_call(12);
    chk_reg(vic_pkg::ADDR_CTRL1, 8'h77);
    exit_pulse(1'b0);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h0e);
    wr_reg(vic_pkg::ADDR_CTRL1, 8'h25);
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h0f);
    no_call(12);
    chk_reg(vic_pkg::ADDR_CTRL1, 8'h25);
    wr_reg(vic_pkg::ADDR_CTRL1, 8'h27);
    wait_call(vic_pkg::VEC_TMRA);
    chk_reg(vic_pkg::ADDR_CTRL1, 8'h07);
    exit_pulse(1'b1);
    end_test("masking");
    // pin edges, nesting by software and the stack limit
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h0e);
    @(posedge clk);
    cmp_out <= 1'b0;
    gext_a <= 1'b1;
    repeat (8) @(posedge clk);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h3e);
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h3f);
    wait_call(vic_pkg::VEC_CMP);
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h2f);
    wait_call(vic_pkg::VEC_GEXT);
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h4f);
    no_call(12);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h4f);
    exit_pulse(1'b0);
    wait_call(vic_pkg::VEC_SEXT);
    end_test("stack");
    // edge selection on grouped line b and the single line, then a reset in mid-run with pins left high
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h0e);
    @(posedge clk);
    sext <= 1'b1;
    gext_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h0e);
    @(posedge clk);
    sext <= 1'b0;
    gext_b <= 1'b0;
    repeat (6) @(posedge clk);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h6e);
    wr_reg(vic_pkg::ADDR_CTRL0, 8'h0e);
    @(posedge clk);
    edge_sel <= 4'hf;
    sext <= 1'b1;
    repeat (6) @(posedge clk);
    chk_reg(vic_pkg::ADDR_CTRL0, 8'h4e);
    end_test("pins");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk_reg(vic_pkg::ADDR_CTRL0, vic_pkg::CTRL0_RST);
    chk_reg(vic_pkg::ADDR_CTRL1, vic_pkg::CTRL1_RST);
    end_test("reset");
    complete_run;
  end
endmodule // tb
